// ===== rtl/smf_mode_ctrl.sv
`timescale 1ns/100ps
`include "smf_regs.svh"

module smf_mode_ctrl #(
    parameter int TEMP_UPDATE_CYCLES =
        `SMF_TEMP_AGE_MS * 1000000 / `SMF_REF_CLK_NS / 2,
    parameter int AGE_W = $clog2(TEMP_UPDATE_CYCLES + 1)
) (
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    input  wire logic               linkClk,
    input  smf_pkg::smf_cmd_t       linkCmd,
    input  wire logic               pdaSelectN,
    input  wire logic               crcEnable,
    input  wire logic               nomTermEnable,
    input  wire logic               parkTermEnable,
    input  wire logic               odtPin,
    input  wire logic               powerDown,
    input  smf_pkg::smf_beat_t      wrBeat,
    input  smf_pkg::smf_rd_t        rdIn,
    input  wire logic [1:0]         tempSensor,
    output smf_pkg::smf_status_t    status,
    output logic [7:0]              wrData,
    output logic                    wrStrobe,
    output logic                    wrByteEn,
    output logic [7:0]              rdDq,
    output logic                    rdInvN,
    output logic                    rdValid,
    output logic                    nomTermOn,
    output logic                    parkTermOn,
    output logic                    internalRefresh
);
    function automatic logic [7:0] crcStep(input logic [7:0] crc,
                                           input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++)
            c = c[7] ? ({c[6:0], 1'b0} ^ `SMF_CRC_POLY) : {c[6:0], 1'b0};
        return c;
    endfunction : crcStep

    function automatic logic [3:0] zeroCount(input logic [7:0] d);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++)
            n = n + {3'h0, ~d[i]};
        return n;
    endfunction : zeroCount

    // Link domain state
    logic [13:0]        mr3, mr4, mr5, next_mr3, next_mr4, next_mr5;
    smf_pkg::smf_gear_t gear, next_gear;
    logic               parErr, crcErr, next_parErr, next_crcErr;
    logic [2:0]         calCnt, next_calCnt;
    logic [3:0]         beatCnt, next_beatCnt;
    logic [7:0]         crcAcc, maskAcc, next_crcAcc, next_maskAcc;
    logic [7:0]         next_wrData, next_rdDq;
    logic               next_wrStrobe, next_wrByteEn;
    logic               next_rdInvN, next_rdValid;
    logic               next_nomTermOn, next_parkTermOn;
    logic               refTgl, next_refTgl;
    logic [1:0]         tempCap, next_tempCap;
    logic [1:0]         linkRstnSync;
    logic [2:0]         tempTglSync;
    // Link domain decode terms
    logic               eValid, parOk, checkPar, cmdGood, max_power_saving_state;
    logic               mrsOk, inv, odtBufOff;
    logic [3:0]         burstLast;
    // Core domain state
    logic [AGE_W-1:0]   ageCnt, next_ageCnt;
    logic [1:0]         tempStat, next_tempStat;
    logic               tempTgl, next_tempTgl;
    logic               refSkip, next_refSkip, next_internalRefresh;
    logic [1:0]         tempEnSync, tcrSync;
    logic [1:0]         sensA, sensB;
    logic [2:0]         refTglSync;
    logic               refEv, tcrLow;

    assign max_power_saving_state = mr4[`SMF_MR4_MAX_POWER_SAVING_STATE];

    assign status.wrCmdLatency = mr3[`SMF_MR3_WCL +: 2];
    assign status.wrPreamble2  = mr4[`SMF_MR4_WPRE];
    assign status.rdPreamble2  = mr4[`SMF_MR4_RPRE];
    assign status.rdPreTrain   = mr4[`SMF_MR4_RPRE_TRAIN];
    assign status.calClocks    = mr4[`SMF_MR4_CAL +: 3];
    assign status.quarterRate  = gear == smf_pkg::SMF_GEAR_QUARTER;
    assign status.maxPowerSave = max_power_saving_state;
    assign status.parityErr    = parErr;
    assign status.crcErr       = crcErr;
    assign status.crcBurst10   = crcEnable;

    // Link domain next state
    always_comb
    begin
        next_mr3 = mr3;
        next_mr4 = mr4;
        next_mr5 = mr5;
        next_gear = gear;
        next_calCnt = calCnt;
        next_refTgl = refTgl;
        next_tempCap = tempCap;
        next_beatCnt = beatCnt;
        next_crcAcc = crcAcc;
        next_maskAcc = maskAcc;
        next_wrData = wrData;
        next_wrStrobe = 1'b0;
        next_wrByteEn = 1'b0;
        // Command sampled after the programmed delay
        eValid = (status.calClocks == 3'h0) ? linkCmd.valid
                                            : calCnt == 3'h1;
        if (calCnt != 3'h0)
            next_calCnt = calCnt - 3'h1;
        else if (linkCmd.valid && status.calClocks != 3'h0)
            next_calCnt = status.calClocks;
        parOk = (^{linkCmd.bank, linkCmd.addr}) == linkCmd.par;
        checkPar = mr5[`SMF_MR5_PAR +: 3] != 3'h0 &&
                   (!parErr || mr5[`SMF_MR5_PAR_KEEP]);
        cmdGood = eValid && !(checkPar && !parOk);
        mrsOk = cmdGood && linkCmd.mrs && !max_power_saving_state &&
                (!mr3[`SMF_MR3_PDA] || !pdaSelectN);
        next_parErr = (eValid && checkPar && !parOk) ||
                      (parErr && !(mrsOk && linkCmd.bank == `SMF_BANK_MR5 &&
                       !linkCmd.addr[`SMF_MR5_PAR_ERR]));
        next_crcErr = crcErr && !(mrsOk && linkCmd.bank == `SMF_BANK_MR5 &&
                      !linkCmd.addr[`SMF_MR5_CRC_ERR]);
        if (mrsOk)
        begin
            unique case (linkCmd.bank)
                `SMF_BANK_MR3: next_mr3 = linkCmd.addr;
                `SMF_BANK_MR4: next_mr4 = linkCmd.addr;
                `SMF_BANK_MR5: next_mr5 = linkCmd.addr;
                default:       next_mr3 = mr3;
            endcase
        end
        if (max_power_saving_state && cmdGood && linkCmd.mpsmExit)
            next_mr4[`SMF_MR4_MAX_POWER_SAVING_STATE] = 1'b0;
        if (cmdGood && linkCmd.refresh && !max_power_saving_state)
            next_refTgl = ~refTgl;
        // Gear-down sequencing
        unique case (gear)
            smf_pkg::SMF_GEAR_HALF:
                if (mrsOk && linkCmd.bank == `SMF_BANK_MR3 &&
                    linkCmd.addr[`SMF_MR3_GEAR])
                    next_gear = smf_pkg::SMF_GEAR_ARMED;
            smf_pkg::SMF_GEAR_ARMED:
                if (linkCmd.syncPulse)
                    next_gear = smf_pkg::SMF_GEAR_QUARTER;
            smf_pkg::SMF_GEAR_QUARTER:
                if (mrsOk && linkCmd.bank == `SMF_BANK_MR3 &&
                    !linkCmd.addr[`SMF_MR3_GEAR])
                    next_gear = smf_pkg::SMF_GEAR_HALF;
            default: next_gear = smf_pkg::SMF_GEAR_HALF;
        endcase
        // Write burst
        burstLast = crcEnable ? `SMF_BURST_LAST_CRC
                              : `SMF_BURST_LAST;
        if (wrBeat.valid && !max_power_saving_state)
        begin
            next_beatCnt = (beatCnt == burstLast) ? 4'h0 : beatCnt + 4'h1;
            if (beatCnt <= `SMF_BURST_LAST)
            begin
                inv = mr5[`SMF_MR5_WR_INV] && !wrBeat.maskInvN;
                next_wrData = inv ? ~wrBeat.dq : wrBeat.dq;
                next_wrStrobe = 1'b1;
                next_wrByteEn = !(mr5[`SMF_MR5_MASK] &&
                                  !wrBeat.maskInvN);
                next_crcAcc = crcStep(crcAcc, wrBeat.dq);
                next_maskAcc[beatCnt[2:0]] = wrBeat.maskInvN;
            end
            else if ((beatCnt == `SMF_CRC_UI && wrBeat.dq != crcAcc) ||
                     (beatCnt == `SMF_MASK_UI && wrBeat.dq !=
                      (mr5[`SMF_MR5_MASK] ? maskAcc : 8'hff)))
                next_crcErr = 1'b1;
            if (beatCnt == burstLast)
            begin
                next_crcAcc = 8'h00;
                next_maskAcc = 8'hff;
            end
        end
        // Read path, mask has no effect here
        next_rdValid = rdIn.valid && !max_power_saving_state;
        inv = 1'b0;
        if (rdIn.train)
        begin
            next_rdDq = 8'h00;
            next_rdDq[`SMF_TRAIN_TEMP +: 2] = tempCap;
        end
        else
        begin
            inv = mr5[`SMF_MR5_RD_INV] && zeroCount(rdIn.dq) > 4'h4;
            next_rdDq = inv ? ~rdIn.dq : rdIn.dq;
        end
        next_rdInvN = !inv;
        if (tempTglSync[2] != tempTglSync[1])
            next_tempCap = tempStat;
        // Termination
        odtBufOff = mr5[`SMF_MR5_ODT_PD] && nomTermEnable;
        next_nomTermOn = nomTermEnable && odtPin &&
                         !(powerDown && odtBufOff);
        next_parkTermOn = parkTermEnable && !next_nomTermOn;
    end

    always_ff @(posedge linkClk)
    begin
        linkRstnSync <= {linkRstnSync[0], rstn};
        tempTglSync <= {tempTglSync[1:0], tempTgl};
        if (!linkRstnSync[1])
        begin
            mr3 <= `SMF_MR_RESET;
            mr4 <= `SMF_MR_RESET;
            mr5 <= `SMF_MR_RESET;
            gear <= smf_pkg::SMF_GEAR_HALF;
            parErr <= 1'b0;
            crcErr <= 1'b0;
            calCnt <= 3'h0;
            beatCnt <= 4'h0;
            crcAcc <= 8'h00;
            maskAcc <= 8'hff;
            wrData <= 8'h00;
            wrStrobe <= 1'b0;
            wrByteEn <= 1'b0;
            rdDq <= 8'h00;
            rdInvN <= 1'b1;
            rdValid <= 1'b0;
            nomTermOn <= 1'b0;
            parkTermOn <= 1'b0;
            refTgl <= 1'b0;
            tempCap <= 2'h0;
        end
        else
        begin
            mr3 <= next_mr3;
            mr4 <= next_mr4;
            mr5 <= next_mr5;
            gear <= next_gear;
            parErr <= next_parErr;
            crcErr <= next_crcErr;
            calCnt <= next_calCnt;
            beatCnt <= next_beatCnt;
            crcAcc <= next_crcAcc;
            maskAcc <= next_maskAcc;
            wrData <= next_wrData;
            wrStrobe <= next_wrStrobe;
            wrByteEn <= next_wrByteEn;
            rdDq <= next_rdDq;
            rdInvN <= next_rdInvN;
            rdValid <= next_rdValid;
            nomTermOn <= next_nomTermOn;
            parkTermOn <= next_parkTermOn;
            refTgl <= next_refTgl;
            tempCap <= next_tempCap;
        end
    end

    // Core domain next state
    always_comb
    begin
        next_ageCnt = ageCnt;
        next_tempStat = tempStat;
        next_tempTgl = tempTgl;
        refEv = refTglSync[2] != refTglSync[1];
        tcrLow = tcrSync[1] && sensB == `SMF_TEMP_LOW;
        if (!tempEnSync[1])
            next_ageCnt = '0;
        else if (ageCnt == AGE_W'(TEMP_UPDATE_CYCLES - 1))
        begin
            next_ageCnt = '0;
            next_tempStat = sensB;
            next_tempTgl = ~tempTgl;
        end
        else
            next_ageCnt = ageCnt + AGE_W'(1);
        next_internalRefresh = refEv && !(tcrLow && refSkip);
        next_refSkip = refEv ? (tcrLow && !refSkip) : refSkip;
    end

    always_ff @(posedge ref_clk)
    begin
        tempEnSync <= {tempEnSync[0], mr3[`SMF_MR3_TEMP]};
        tcrSync <= {tcrSync[0], mr4[`SMF_MR4_TCR]};
        sensA <= tempSensor;
        sensB <= sensA;
        refTglSync <= {refTglSync[1:0], refTgl};
        if (!rstn)
        begin
            ageCnt <= '0;
            tempStat <= 2'h0;
            tempTgl <= 1'b0;
            refSkip <= 1'b0;
            internalRefresh <= 1'b0;
        end
        else
        begin
            ageCnt <= next_ageCnt;
            tempStat <= next_tempStat;
            tempTgl <= next_tempTgl;
            refSkip <= next_refSkip;
            internalRefresh <= next_internalRefresh;
        end
    end
endmodule : smf_mode_ctrl

// ===== rtl/smf_regs.svh
`ifndef SMF_REGS_SVH
`define SMF_REGS_SVH
// Mode register select codes on the bank lines
`define SMF_BANK_MR3        3'h3
`define SMF_BANK_MR4        3'h4
`define SMF_BANK_MR5        3'h5
// Field positions, mode_reg_three
`define SMF_MR3_GEAR        3
`define SMF_MR3_PDA         4
`define SMF_MR3_TEMP        5
`define SMF_MR3_WCL         9
// Field positions, mode_reg_four
`define SMF_MR4_MAX_POWER_SAVING_STATE        1
`define SMF_MR4_TCR         3
`define SMF_MR4_CAL         6
`define SMF_MR4_RPRE_TRAIN  10
`define SMF_MR4_RPRE        11
`define SMF_MR4_WPRE        12
// Field positions, mode_reg_five
`define SMF_MR5_PAR         0
`define SMF_MR5_CRC_ERR     3
`define SMF_MR5_PAR_ERR     4
`define SMF_MR5_ODT_PD      5
`define SMF_MR5_PAR_KEEP    9
`define SMF_MR5_MASK        10
`define SMF_MR5_WR_INV      11
`define SMF_MR5_RD_INV      12
// Reset values and burst shape
`define SMF_MR_RESET        14'h0000
`define SMF_BURST_LAST      4'h7
`define SMF_BURST_LAST_CRC  4'h9
`define SMF_CRC_UI          4'h8
`define SMF_MASK_UI         4'h9
`define SMF_CRC_POLY        8'h07
`define SMF_TRAIN_TEMP      3
`define SMF_TEMP_LOW        2'h0
// Timing
`define SMF_TEMP_AGE_MS     32
`define SMF_REF_CLK_NS      40
`endif

// ===== rtl/smf_pkg.sv
package smf_pkg;
    typedef struct packed {
        logic        valid;
        logic        mrs;
        logic        refresh;
        logic        mpsmExit;
        logic        syncPulse;
        logic [2:0]  bank;
        logic [13:0] addr;
        logic        par;
    } smf_cmd_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] dq;
        logic       maskInvN;
    } smf_beat_t;

    typedef struct packed {
        logic       valid;
        logic       train;
        logic [7:0] dq;
    } smf_rd_t;

    typedef struct packed {
        logic [1:0] wrCmdLatency;
        logic       wrPreamble2;
        logic       rdPreamble2;
        logic       rdPreTrain;
        logic [2:0] calClocks;
        logic       quarterRate;
        logic       maxPowerSave;
        logic       parityErr;
        logic       crcErr;
        logic       crcBurst10;
    } smf_status_t;

    typedef enum logic [1:0] {
        SMF_GEAR_HALF    = 2'h0,
        SMF_GEAR_ARMED   = 2'h1,
        SMF_GEAR_QUARTER = 2'h3
    } smf_gear_t;
endpackage : smf_pkg

// ===== tb/smf_mode_ctrl_sva.sv
`timescale 1ns/100ps
module smf_mode_ctrl_sva #(
    parameter int TEMP_UPDATE_CYCLES = 20
) (
    input wire logic            linkClk,
    input wire logic            rstn,
    input smf_pkg::smf_cmd_t    linkCmd,
    input wire logic            crcEnable,
    input wire logic            nomTermEnable,
    input smf_pkg::smf_beat_t   wrBeat,
    input smf_pkg::smf_rd_t     rdIn,
    input smf_pkg::smf_status_t status,
    input wire logic            wrStrobe,
    input wire logic            wrByteEn,
    input wire logic            rdInvN,
    input wire logic            nomTermOn
);
    default clocking cb @(posedge linkClk);
    endclocking
    default disable iff (!rstn);
    wire modeFiveWr = linkCmd.valid && linkCmd.mrs && linkCmd.bank == 3'h5;

    a_beat_strobe:
        assert property (wrStrobe |-> $past(wrBeat.valid))
        else $error("write strobe without a beat");
    a_crc_frame:
        assert property (status.crcBurst10 == crcEnable)
        else $error("burst length flag differs from crc enable");
    a_mask_write:
        assert property (wrStrobe && !wrByteEn |->
            $past(wrBeat.valid && !wrBeat.maskInvN))
        else $error("byte dropped without mask");
    a_train_plain:
        assert property ($past(rdIn.valid && rdIn.train) |-> rdInvN)
        else $error("training read inverted");
    a_nom_off:
        assert property (!$past(nomTermEnable) |-> !nomTermOn)
        else $error("nominal termination while disabled");
    a_gear_sync:
        assert property ($rose(status.quarterRate) |->
            $past(linkCmd.syncPulse))
        else $error("quarter rate without sync pulse");
    a_save_hold:
        assert property (status.maxPowerSave |=>
            $stable(status.wrCmdLatency))
        else $error("command acted on in power save");
    a_par_sticky:
        assert property ($fell(status.parityErr) |-> $past(modeFiveWr))
        else $error("parity error cleared without command");
    a_crc_sticky:
        assert property ($fell(status.crcErr) |-> $past(modeFiveWr))
        else $error("crc error cleared without command");
endmodule : smf_mode_ctrl_sva

bind smf_mode_ctrl smf_mode_ctrl_sva #(
    .TEMP_UPDATE_CYCLES(TEMP_UPDATE_CYCLES)
) u_smf_mode_ctrl_sva (
    .linkClk(linkClk), .rstn(rstn), .linkCmd(linkCmd),
    .crcEnable(crcEnable), .nomTermEnable(nomTermEnable),
    .wrBeat(wrBeat), .rdIn(rdIn), .status(status),
    .wrStrobe(wrStrobe), .wrByteEn(wrByteEn), .rdInvN(rdInvN),
    .nomTermOn(nomTermOn)
);

// ===== tb/smf_host_model.sv
`timescale 1ns/100ps
// Controller side: commands, write bursts, read beats
module smf_host_model (
    input  wire logic           linkClk,
    output smf_pkg::smf_cmd_t   linkCmd,
    output smf_pkg::smf_beat_t  wrBeat,
    output smf_pkg::smf_rd_t    rdIn
);
    initial
    begin
        linkCmd = '0;
        wrBeat = '0;
        rdIn = '0;
    end
    // Kind is mrs, refresh, exit, sync; reserved bits go as zero
    task automatic send(input logic [3:0] k, input logic [2:0] b,
                        input logic [13:0] a, input logic bad);
        @(negedge linkClk);
        linkCmd = {|k[3:1], k, b, a, ^{b, a} ^ bad};
        @(negedge linkClk);
        linkCmd = {5'h00, ~b, ~a, 1'b0};
        @(negedge linkClk);
    endtask : send
    task automatic burst(input logic [79:0] d, input logic [7:0] m,
                         input int n);
        for (int i = 0; i < n; i++)
        begin
            @(negedge linkClk);
            wrBeat = {1'b1, d[8*i +: 8], (i > 7) | m[i % 8]};
        end
        @(negedge linkClk);
        wrBeat = {1'b0, ~wrBeat.dq, 1'b1};
        @(negedge linkClk);
    endtask : burst
    task automatic rd(input logic [7:0] dq, input logic train);
        @(negedge linkClk);
        rdIn = {1'b1, train, dq};
        @(negedge linkClk);
        rdIn = {2'b00, ~dq};
        repeat (2) @(negedge linkClk);
    endtask : rd
endmodule : smf_host_model

// ===== tb/smf_mode_ctrl_bench.sv
`timescale 1ns/100ps
module smf_mode_ctrl_bench;
    localparam logic [63:0] DAT = 64'h0123456789abcdef;
    logic                 ref_clk, linkClk, rstn, pdaSelectN, crcEnable;
    logic                 nomTermEnable, parkTermEnable, odtPin, powerDown;
    logic                 wrStrobe, wrByteEn, rdInvN, rdValid;
    logic                 nomTermOn, parkTermOn, internalRefresh;
    logic [1:0]           tempSensor;
    logic [7:0]           wrData, rdDq, lastWr;
    logic [8:0]           lastRd;
    smf_pkg::smf_cmd_t    linkCmd;
    smf_pkg::smf_beat_t   wrBeat;
    smf_pkg::smf_rd_t     rdIn;
    smf_pkg::smf_status_t status;
    int                   err_count = 0;
    int                   checks_done = 0;
    int                   strobes = 0;
    int                   masked = 0;
    int                   refs = 0;

    smf_mode_ctrl #(.TEMP_UPDATE_CYCLES(20)) u_smf_mode_ctrl (
        .ref_clk(ref_clk), .rstn(rstn), .linkClk(linkClk),
        .linkCmd(linkCmd), .pdaSelectN(pdaSelectN),
        .crcEnable(crcEnable), .nomTermEnable(nomTermEnable),
        .parkTermEnable(parkTermEnable), .odtPin(odtPin),
        .powerDown(powerDown), .wrBeat(wrBeat), .rdIn(rdIn),
        .tempSensor(tempSensor), .status(status), .wrData(wrData),
        .wrStrobe(wrStrobe), .wrByteEn(wrByteEn), .rdDq(rdDq),
        .rdInvN(rdInvN), .rdValid(rdValid), .nomTermOn(nomTermOn),
        .parkTermOn(parkTermOn), .internalRefresh(internalRefresh)
    );
    smf_host_model u_smf_host_model (
        .linkClk(linkClk), .linkCmd(linkCmd), .wrBeat(wrBeat), .rdIn(rdIn)
    );

    initial
    begin
        ref_clk = 1'b0;
        linkClk = 1'b0;
        fork
            forever #20 ref_clk = ~ref_clk;
            #7 forever #32 linkClk = ~linkClk;
        join
    end
    always @(posedge linkClk)
        if (wrStrobe === 1'b1)
        begin
            strobes++;
            masked += (wrByteEn === 1'b0);
            lastWr = wrData;
        end
    always @(posedge linkClk or posedge ref_clk)
        if (rdValid === 1'b1)
            lastRd = {rdInvN, rdDq};
    always @(posedge ref_clk)
        refs += (internalRefresh === 1'b1);

    function automatic logic [7:0] crc8(input logic [63:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 64; i++)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[8*(i/8)+7-i%8]) ? 8'h07 : 8'h00);
        return c;
    endfunction : crc8
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic mr(input logic [2:0] b, input logic [13:0] a,
                      input logic [3:0] k = 4'h8, input logic bad = 1'b0);
        u_smf_host_model.send(k, b, a, bad);
    endtask : mr
    task automatic lvl(input logic [4:0] v);
        @(negedge linkClk);
        {crcEnable, nomTermEnable, parkTermEnable, odtPin, powerDown} = v;
        repeat (3) @(negedge linkClk);
    endtask : lvl
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // Hang guard
    initial
    begin
        #400000;
        err_count++;
        end_sim();
    end

    initial
    begin
        rstn = 1'b0;
        pdaSelectN = 1'b0;
        tempSensor = 2'h0;
        {crcEnable, nomTermEnable, parkTermEnable, odtPin, powerDown} = 5'h0;
        repeat (6) @(negedge ref_clk);
        chk("reset", 16'h2000, {rdInvN, status});
        rstn = 1'b1;
        repeat (4) @(negedge linkClk);
        mr(3'h4, 14'h1c00);
        chk("preambles", 7, {status.wrPreamble2, status.rdPreamble2,
            status.rdPreTrain});
        mr(3'h3, 14'h0200);
        chk("wr latency", 1, status.wrCmdLatency);
        mr(3'h3, 14'h0400);
        chk("wr latency five", 2, status.wrCmdLatency);
        mr(3'h3, 14'h0208);
        chk("gear armed", 0, status.quarterRate);
        mr(3'h0, 14'h0000, 4'h1);
        chk("gear quarter", 1, status.quarterRate);
        mr(3'h3, 14'h0200);
        chk("gear half", 0, status.quarterRate);
        mr(3'h4, 14'h0002);
        mr(3'h3, 14'h0400);
        chk("power save", 3, {status.wrCmdLatency, status.maxPowerSave});
        mr(3'h0, 14'h0000, 4'h2);
        chk("save exit", 2, {status.wrCmdLatency, status.maxPowerSave});
        mr(3'h5, 14'h0001);
        repeat (2) mr(3'h3, 14'h0400, 4'h8, 1'b1);
        chk("parity drop", 5, {status.wrCmdLatency, status.parityErr});
        mr(3'h5, 14'h0201);
        chk("parity clear", 0, status.parityErr);
        repeat (2) mr(3'h3, 14'h0000, 4'h8, 1'b1);
        chk("parity keep", 5, {status.wrCmdLatency, status.parityErr});
        mr(3'h5, 14'h0000);
        mr(3'h4, 14'h0008);
        repeat (2) mr(3'h0, 14'h0000, 4'h4);
        repeat (8) @(negedge ref_clk);
        chk("refreshes", 1, refs);
        mr(3'h4, 14'h0000);
        lvl(5'h06);
        chk("nom off", 1, {nomTermOn, parkTermOn});
        lvl(5'h10);
        chk("crc frame", 1, status.crcBurst10);
        strobes = 0;
        u_smf_host_model.burst({8'hff, crc8(DAT), DAT}, 8'hff, 10);
        chk("crc beats", 8, {status.crcErr, strobes[7:0]});
        u_smf_host_model.burst({8'hff, ~crc8(DAT), DAT}, 8'hff, 10);
        chk("crc bad", 1, status.crcErr);
        u_smf_host_model.burst({8'hff, crc8(DAT), DAT}, 8'hff, 10);
        chk("crc sticky", 1, status.crcErr);
        mr(3'h5, 14'h0000);
        chk("crc clear", 0, status.crcErr);
        lvl(5'h00);
        mr(3'h5, 14'h0400);
        u_smf_host_model.burst({16'h0, DAT}, 8'hfe, 8);
        chk("masked", 1, masked);
        u_smf_host_model.rd(8'h0f, 1'b0);
        chk("read unmasked", 9'h10f, lastRd);
        mr(3'h5, 14'h0800);
        u_smf_host_model.burst({16'h0, {8{8'h3c}}}, 8'h00, 8);
        chk("write inverted", 9'h1c3, {masked[0], lastWr});
        mr(3'h5, 14'h1000);
        u_smf_host_model.rd(8'h01, 1'b0);
        chk("read inverted", 9'h0fe, lastRd);
        @(negedge ref_clk);
        tempSensor = 2'h2;
        mr(3'h3, 14'h0020);
        repeat (80) @(negedge ref_clk);
        u_smf_host_model.rd(8'h00, 1'b1);
        chk("train plain", 1, lastRd[8]);
        chk("temp status", 2, lastRd[4:3]);
        mr(3'h3, 14'h0010);
        @(negedge linkClk);
        pdaSelectN = 1'b1;
        mr(3'h4, 14'h1000);
        chk("device skip", 0, status.wrPreamble2);
        @(negedge linkClk);
        pdaSelectN = 1'b0;
        mr(3'h4, 14'h1000);
        chk("device take", 1, status.wrPreamble2);
        end_sim();
    end
endmodule : smf_mode_ctrl_bench
